// *** srm_eng_model.sv ***
`timescale 1ns/1ps
module srm_eng_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // bench command: word holds alarm, units, value
  input wire logic req,
  input wire logic [1:0] req_src,
  input wire logic [3:0] req_chan,
  input wire logic [31:0] req_word,
  input wire logic mon_req,
  // sample port
  output logic smp_valid,
  output logic [1:0] smp_src,
  output logic [23:0] smp_value,
  output logic [3:0] smp_units,
  output logic [31:0] smp_time,
  output logic [3:0] smp_chan,
  output logic [1:0] smp_alarm
);
  logic [31:0] tick;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick <= 32'h0;
      smp_valid <= 1'b0;
      smp_src <= 2'h0;
      smp_value <= 24'h0;
      smp_units <= 4'h0;
      smp_time <= 32'h0;
      smp_chan <= 4'h0;
      smp_alarm <= 2'h0;
    end else begin
      tick <= tick + 32'h1;
      // a monitor sample is taken only when the store asks for one
      smp_valid <= req && (req_src != srm_pkg::SRC_MON || mon_req);
      if (req) begin
        smp_src <= req_src;
        smp_value <= req_word[23:0];
        smp_units <= req_word[27:24];
        smp_alarm <= req_word[29:28];
        smp_chan <= req_chan;
        smp_time <= tick;
      end else begin
        // idle value and time lines toggle so stale data never looks valid
        smp_value <= ~smp_value;
        smp_time <= ~smp_time;
      end
    end
  end
endmodule

// *** srm_pkg.sv ***
package srm_pkg;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_MON_CHAN = 8'h08;
  localparam logic [7:0] A_SCAN_LIST = 8'h0C;
  localparam logic [7:0] A_COUNT = 8'h10;
  localparam logic [7:0] A_REC_IDX = 8'h14;
  localparam logic [7:0] A_REC_VAL = 8'h18;
  localparam logic [7:0] A_REC_TIME = 8'h1C;
  localparam logic [7:0] A_REC_TAG = 8'h20;
  localparam logic [7:0] A_REMOVE = 8'h24;
  localparam logic [7:0] A_STAT_CHAN = 8'h28;
  localparam logic [7:0] A_MIN = 8'h2C;
  localparam logic [7:0] A_MIN_T = 8'h30;
  localparam logic [7:0] A_MAX = 8'h34;
  localparam logic [7:0] A_MAX_T = 8'h38;
  localparam logic [7:0] A_AVG = 8'h3C;
  localparam logic [7:0] A_SCNT = 8'h40;
  localparam logic [7:0] A_PTP = 8'h44;
  localparam logic [7:0] A_LAST = 8'h48;
  localparam logic [7:0] A_STAT_CLR = 8'h4C;
  localparam logic [7:0] A_MON_VAL = 8'h50;
  localparam logic [7:0] A_DELAY = 8'h54;
  localparam logic [7:0] A_MON_LO = 8'h58;
  localparam logic [7:0] A_MON_HI = 8'h5C;
  localparam logic [7:0] A_ALQ = 8'h60;
  // field positions
  localparam int CTRL_MON_EN = 0;
  localparam int CTRL_PRESET = 1;
  localparam int ST_OVF = 0;
  localparam int ST_SCAN = 1;
  localparam int ST_MON_OK = 2;
  localparam int TAG_ALARM = 4;
  localparam int TAG_CHAN = 8;
  localparam int DLY_AUTO = 31;
  localparam int ALQ_VALID = 31;
  // alarm codes
  localparam logic [1:0] ALM_NONE = 2'h0;
  localparam logic [1:0] ALM_LO = 2'h1;
  localparam logic [1:0] ALM_HI = 2'h2;
  // sample sources
  localparam logic [1:0] SRC_SCAN = 2'h0;
  localparam logic [1:0] SRC_MON = 2'h1;
  localparam logic [1:0] SRC_IMM = 2'h2;
  // function classes and ac filters
  localparam logic [1:0] FN_OTHER = 2'h0;
  localparam logic [1:0] FN_AC = 2'h1;
  localparam logic [1:0] FN_FREQ = 2'h2;
  localparam logic [1:0] FN_DIG = 2'h3;
  localparam logic [1:0] FLT_SLOW = 2'h0;
  localparam logic [1:0] FLT_MED = 2'h1;
  // automatic settle delays in ms
  localparam logic [15:0] AC_SLOW_MS = 16'h1B58;
  localparam logic [15:0] AC_MED_MS = 16'h03E8;
  localparam logic [15:0] AC_FAST_MS = 16'h0078;
  localparam logic [15:0] FQ_SLOW_MS = 16'h0258;
  localparam logic [15:0] FQ_MED_MS = 16'h012C;
  localparam logic [15:0] FQ_FAST_MS = 16'h0064;
  localparam logic [15:0] DIG_MS = 16'h0000;
endpackage

// *** srm_store.sv ***
`timescale 1ns/1ps
// Operation
// - auto settle for ac: 7.0 s slow, 1.0 s medium, 120 ms fast.
// - writing an explicit channel delay disables its auto delay.
// - records are stored only while a scan is active.
// - store holds 50,000 records; when full flag overflow and overwrite oldest.
// - starting a scan empties the store and clears its sample counts and sums; the alarm queue is kept.
// - preset or factory reset empties the store.
// - reading records back leaves records and count unchanged.
// - per-channel min, max, average tracked and readable any time.
// - record holds value, units, time stamp, channel, alarm status.
// - monitor samples are not stored; concurrent scan samples are.
// - immediate samples go to the output register, not the store.
// - report min, max, their times, average, count, peak-to-peak.
// - report last scan value of a chosen channel.
// - statistics clear resets only the addressed channel.
// - report total number of records held.
// - remove request returns and deletes N oldest records.
// - monitor samples one selectable channel continuously.
// - scan beats monitor; at least one monitor sample per sweep.
// - alarm limits apply to monitor; alarms go to volatile queue.
// - monitoring never resets a totalizer count.
// - monitor query returns bare value only.
// - mux channel monitor needs meter present and channel in scan list.
// - alarm field: 0 none, 1 low, 2 high.
module srm_store #(
  parameter int DEPTH = 50000,
  parameter int CH = 16,
  parameter int VW = 24,
  parameter int TW = 32,
  parameter int AQ = 4,
  parameter logic [15:0] OTHER_MS = 16'h0001
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // scan engine
  input wire logic scan_start,
  input wire logic scan_active,
  input wire logic sweep_end,
  input wire logic engine_idle,
  input wire logic meter_ok,
  input wire logic mon_mux,
  input wire logic smp_valid,
  input wire logic [1:0] smp_src,
  input wire logic [VW-1:0] smp_value,
  input wire logic [3:0] smp_units,
  input wire logic [TW-1:0] smp_time,
  input wire logic [$clog2(CH)-1:0] smp_chan,
  input wire logic [1:0] smp_alarm,
  // settle delay lookup
  input wire logic set_req,
  input wire logic [$clog2(CH)-1:0] set_chan,
  input wire logic [1:0] set_func,
  input wire logic [1:0] set_filter,
  output logic [15:0] settle_ms,
  output logic settle_vld,
  // monitor, immediate and overflow outputs
  output logic mon_req,
  output logic [$clog2(CH)-1:0] mon_chan,
  output logic tot_hold,
  output logic [VW-1:0] imm_value,
  output logic imm_vld,
  output logic mem_ovf_led
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(CH);
  localparam int SW = VW + 32;
  localparam int RW = 4 + 2 + CW + TW + VW;
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
  localparam logic [PW+1:0] DEP2 = (PW+2)'(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    logic [PW:0] rec_idx;
    logic [31:0] rem_left;
    logic ovf;
    logic mon_en;
    logic [CW-1:0] mon_chan;
    logic [CW-1:0] stat_chan;
    logic [CH-1:0] scan_list;
    logic [CH-1:0] auto_dly;
    logic [CH-1:0][15:0] dly;
    logic [VW-1:0] mon_val;
    logic [VW-1:0] mon_lo;
    logic [VW-1:0] mon_hi;
    logic mon_taken;
    logic mon_owed;
    logic mon_req;
    logic tot_hold;
    logic [15:0] settle_ms;
    logic settle_vld;
    logic [VW-1:0] imm_val;
    logic imm_vld;
    logic [AQ-1:0][CW+1:0] aq;
    logic [$clog2(AQ):0] aq_cnt;
    logic [CH-1:0][VW-1:0] mn;
    logic [CH-1:0][VW-1:0] mx;
    logic [CH-1:0][VW-1:0] last;
    logic [CH-1:0][TW-1:0] mn_t;
    logic [CH-1:0][TW-1:0] mx_t;
    logic [CH-1:0][SW-1:0] sum;
    logic [CH-1:0][31:0] scnt;
    logic [31:0] rdata;
  } srm_st_t;

  srm_st_t s_q;
  srm_st_t s_d;
  logic [RW-1:0] mem [DEPTH];
  logic clr_w;
  logic store_we;
  logic pop_w;
  logic mon_ok;
  logic mon_smp;
  logic [PW-1:0] wr_addr;
  logic [PW-1:0] rec_phys;
  logic rec_hit;
  logic [RW-1:0] rec_rd;
  logic [1:0] mon_alm;

  function automatic logic [PW-1:0] srm_wrap(input logic [PW-1:0] a,
                                             input logic [PW:0] b);
    logic [PW+1:0] t;
    t = {2'h0, a} + {1'h0, b};
    if (t >= DEP2) begin
      t = t - DEP2;
    end
    return t[PW-1:0];
  endfunction

  function automatic logic [31:0] srm_sx(input logic [VW-1:0] v);
    return 32'($signed(v));
  endfunction

  function automatic logic [31:0] srm_avg(input logic [SW-1:0] s,
                                          input logic [31:0] n);
    logic signed [SW:0] q;
    q = '0;
    if (n != 32'h0) begin
      q = $signed({s[SW-1], s}) / $signed({1'h0, n});
    end
    return q[31:0];
  endfunction

  assign clr_w = scan_start || (wr && addr == srm_pkg::A_CTRL &&
                 wdata[srm_pkg::CTRL_PRESET]);
  assign store_we = smp_valid && smp_src == srm_pkg::SRC_SCAN &&
                    scan_active;
  assign mon_smp = smp_valid && smp_src == srm_pkg::SRC_MON;
  assign mon_ok = s_q.mon_en && (!mon_mux ||
                  (meter_ok && s_q.scan_list[s_q.mon_chan]));
  assign pop_w = rd && addr == srm_pkg::A_REC_TAG &&
                 s_q.rem_left != 32'h0 && s_q.count != '0;
  assign wr_addr = clr_w ? '0 : s_q.wr_ptr;
  // while removing, record reads always look at the oldest record
  assign rec_phys = srm_wrap(s_q.rd_ptr,
                             s_q.rem_left != 32'h0 ? '0 : s_q.rec_idx);
  assign rec_hit = s_q.rem_left != 32'h0 ? s_q.count != '0 :
                   s_q.rec_idx < s_q.count;
  assign rec_rd = mem[rec_phys];
  assign mon_alm = $signed(smp_value) < $signed(s_q.mon_lo) ?
                   srm_pkg::ALM_LO : ($signed(smp_value) >
                   $signed(s_q.mon_hi) ? srm_pkg::ALM_HI :
                   srm_pkg::ALM_NONE);

  always_ff @(posedge sys_clk) begin
    if (ce && store_we) begin
      mem[wr_addr] <= {smp_units, smp_alarm, smp_chan, smp_time,
                       smp_value};
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.rdata = '0;
    s_d.imm_vld = 1'b0;
    s_d.settle_vld = 1'b0;
    if (clr_w) begin
      s_d.wr_ptr = '0;
      s_d.rd_ptr = '0;
      s_d.count = '0;
      s_d.ovf = 1'b0;
      s_d.rem_left = '0;
      s_d.scnt = '0;
      s_d.sum = '0;
    end
    if (wr) begin
      case (addr)
        srm_pkg::A_CTRL: s_d.mon_en = wdata[srm_pkg::CTRL_MON_EN];
        srm_pkg::A_MON_CHAN: s_d.mon_chan = wdata[CW-1:0];
        srm_pkg::A_SCAN_LIST: s_d.scan_list = wdata[CH-1:0];
        srm_pkg::A_REC_IDX: s_d.rec_idx = wdata[PW:0];
        srm_pkg::A_REMOVE: s_d.rem_left = wdata;
        srm_pkg::A_STAT_CHAN: s_d.stat_chan = wdata[CW-1:0];
        srm_pkg::A_STAT_CLR: begin
          s_d.scnt[wdata[CW-1:0]] = '0;
          s_d.sum[wdata[CW-1:0]] = '0;
          s_d.mn[wdata[CW-1:0]] = '0;
          s_d.mx[wdata[CW-1:0]] = '0;
        end
        srm_pkg::A_DELAY: begin
          if (wdata[srm_pkg::DLY_AUTO]) begin
            s_d.auto_dly[wdata[16+CW-1:16]] = 1'b1;
          end else begin
            s_d.auto_dly[wdata[16+CW-1:16]] = 1'b0;
            s_d.dly[wdata[16+CW-1:16]] = wdata[15:0];
          end
        end
        srm_pkg::A_MON_LO: s_d.mon_lo = wdata[VW-1:0];
        srm_pkg::A_MON_HI: s_d.mon_hi = wdata[VW-1:0];
        default: ;
      endcase
    end
    if (rd) begin
      case (addr)
        srm_pkg::A_CTRL: s_d.rdata[srm_pkg::CTRL_MON_EN] = s_q.mon_en;
        srm_pkg::A_STATUS: begin
          s_d.rdata[srm_pkg::ST_OVF] = s_q.ovf;
          s_d.rdata[srm_pkg::ST_SCAN] = scan_active;
          s_d.rdata[srm_pkg::ST_MON_OK] = mon_ok;
        end
        srm_pkg::A_MON_CHAN: s_d.rdata[CW-1:0] = s_q.mon_chan;
        srm_pkg::A_SCAN_LIST: s_d.rdata[CH-1:0] = s_q.scan_list;
        srm_pkg::A_COUNT: s_d.rdata[PW:0] = s_q.count;
        srm_pkg::A_REC_IDX: s_d.rdata[PW:0] = s_q.rec_idx;
        srm_pkg::A_REC_VAL: begin
          if (rec_hit) s_d.rdata = srm_sx(rec_rd[VW-1:0]);
        end
        srm_pkg::A_REC_TIME: begin
          if (rec_hit) s_d.rdata[TW-1:0] = rec_rd[VW+TW-1:VW];
        end
        srm_pkg::A_REC_TAG: begin
          if (rec_hit) begin
            s_d.rdata[3:0] = rec_rd[RW-1:RW-4];
            s_d.rdata[srm_pkg::TAG_ALARM+:2] = rec_rd[RW-5:RW-6];
            s_d.rdata[srm_pkg::TAG_CHAN+:CW] = rec_rd[VW+TW+:CW];
          end
        end
        srm_pkg::A_REMOVE: s_d.rdata = s_q.rem_left;
        srm_pkg::A_STAT_CHAN: s_d.rdata[CW-1:0] = s_q.stat_chan;
        srm_pkg::A_MIN: s_d.rdata = srm_sx(s_q.mn[s_q.stat_chan]);
        srm_pkg::A_MIN_T: s_d.rdata[TW-1:0] = s_q.mn_t[s_q.stat_chan];
        srm_pkg::A_MAX: s_d.rdata = srm_sx(s_q.mx[s_q.stat_chan]);
        srm_pkg::A_MAX_T: s_d.rdata[TW-1:0] = s_q.mx_t[s_q.stat_chan];
        srm_pkg::A_AVG: s_d.rdata = srm_avg(s_q.sum[s_q.stat_chan],
                                            s_q.scnt[s_q.stat_chan]);
        srm_pkg::A_SCNT: s_d.rdata = s_q.scnt[s_q.stat_chan];
        srm_pkg::A_PTP: s_d.rdata = srm_sx(s_q.mx[s_q.stat_chan]) -
                                    srm_sx(s_q.mn[s_q.stat_chan]);
        srm_pkg::A_LAST: s_d.rdata = srm_sx(s_q.last[s_q.stat_chan]);
        srm_pkg::A_MON_VAL: s_d.rdata = srm_sx(s_q.mon_val);
        srm_pkg::A_DELAY: begin
          s_d.rdata[15:0] = s_q.dly[s_q.stat_chan];
          s_d.rdata[srm_pkg::DLY_AUTO] = s_q.auto_dly[s_q.stat_chan];
        end
        srm_pkg::A_MON_LO: s_d.rdata = srm_sx(s_q.mon_lo);
        srm_pkg::A_MON_HI: s_d.rdata = srm_sx(s_q.mon_hi);
        srm_pkg::A_ALQ: begin
          if (s_q.aq_cnt != '0) begin
            s_d.rdata[CW+1:0] = s_q.aq[0];
            s_d.rdata[srm_pkg::ALQ_VALID] = 1'b1;
            for (int i = 0; i < AQ - 1; i++) begin
              s_d.aq[i] = s_q.aq[i+1];
            end
            s_d.aq_cnt = s_q.aq_cnt - 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (pop_w && !clr_w) begin
      s_d.rd_ptr = srm_wrap(s_q.rd_ptr, (PW+1)'(1));
      s_d.count = s_q.count - 1'b1;
      s_d.rem_left = s_q.rem_left - 32'h1;
    end
    if (store_we) begin
      s_d.wr_ptr = srm_wrap(s_d.wr_ptr, (PW+1)'(1));
      if (s_d.count == FULL) begin
        s_d.rd_ptr = srm_wrap(s_d.rd_ptr, (PW+1)'(1));
        s_d.ovf = 1'b1;
      end else begin
        s_d.count = s_d.count + 1'b1;
      end
      if (s_d.scnt[smp_chan] == '0 ||
          $signed(smp_value) < $signed(s_d.mn[smp_chan])) begin
        s_d.mn[smp_chan] = smp_value;
        s_d.mn_t[smp_chan] = smp_time;
      end
      if (s_d.scnt[smp_chan] == '0 ||
          $signed(smp_value) > $signed(s_d.mx[smp_chan])) begin
        s_d.mx[smp_chan] = smp_value;
        s_d.mx_t[smp_chan] = smp_time;
      end
      s_d.sum[smp_chan] = s_d.sum[smp_chan] + SW'($signed(smp_value));
      s_d.scnt[smp_chan] = s_d.scnt[smp_chan] + 32'h1;
      s_d.last[smp_chan] = smp_value;
    end
    if (smp_valid && smp_src == srm_pkg::SRC_IMM) begin
      s_d.imm_val = smp_value;
      s_d.imm_vld = 1'b1;
    end
    if (sweep_end) begin
      s_d.mon_owed = !s_q.mon_taken;
      s_d.mon_taken = 1'b0;
    end
    if (mon_smp) begin
      s_d.mon_val = smp_value;
      s_d.mon_taken = 1'b1;
      s_d.mon_owed = 1'b0;
      if (mon_alm != srm_pkg::ALM_NONE && s_d.aq_cnt < ($clog2(AQ)+1)'(AQ))
      begin
        s_d.aq[s_d.aq_cnt] = {s_q.mon_chan, mon_alm};
        s_d.aq_cnt = s_d.aq_cnt + 1'b1;
      end
    end
    s_d.mon_req = mon_ok && (!scan_active || engine_idle ||
                  s_d.mon_owed);
    s_d.tot_hold = mon_ok;
    if (set_req) begin
      s_d.settle_vld = 1'b1;
      if (!s_q.auto_dly[set_chan]) begin
        s_d.settle_ms = s_q.dly[set_chan];
      end else begin
        case (set_func)
          srm_pkg::FN_AC: s_d.settle_ms =
            set_filter == srm_pkg::FLT_SLOW ? srm_pkg::AC_SLOW_MS :
            set_filter == srm_pkg::FLT_MED ? srm_pkg::AC_MED_MS :
            srm_pkg::AC_FAST_MS;
          srm_pkg::FN_FREQ: s_d.settle_ms =
            set_filter == srm_pkg::FLT_SLOW ? srm_pkg::FQ_SLOW_MS :
            set_filter == srm_pkg::FLT_MED ? srm_pkg::FQ_MED_MS :
            srm_pkg::FQ_FAST_MS;
          srm_pkg::FN_DIG: s_d.settle_ms = srm_pkg::DIG_MS;
          default: s_d.settle_ms = OTHER_MS;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.auto_dly <= '1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign settle_ms = s_q.settle_ms;
  assign settle_vld = s_q.settle_vld;
  assign mon_req = s_q.mon_req;
  assign mon_chan = s_q.mon_chan;
  assign tot_hold = s_q.tot_hold;
  assign imm_value = s_q.imm_val;
  assign imm_vld = s_q.imm_vld;
  assign mem_ovf_led = s_q.ovf;

  default clocking srm_cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  count_sat_a: assert property (s_q.count <= FULL)
    else $error("record count above capacity");
  ovf_set_a: assert property (ce && store_we && !clr_w && !pop_w &&
    s_q.count == FULL |=> s_q.ovf && s_q.count == FULL)
    else $error("overflow not flagged on full write");
  idle_write_a: assert property (ce && !scan_active && !clr_w &&
    !pop_w |=> s_q.count == $past(s_q.count))
    else $error("store changed outside a scan");
  start_clr_a: assert property (ce && scan_start && !store_we
    |=> s_q.count == '0 && !s_q.ovf)
    else $error("scan start did not empty store");
  preset_clr_a: assert property (ce && clr_w && !scan_start &&
    !store_we |=> s_q.count == '0)
    else $error("preset did not empty store");
  read_keep_a: assert property (ce && rd && addr == srm_pkg::A_REC_VAL &&
    !store_we && !clr_w |=> $stable(s_q.count))
    else $error("record read changed count");
  pop_dec_a: assert property (ce && pop_w && !store_we && !clr_w
    |=> s_q.count == $past(s_q.count) - 1'b1)
    else $error("remove did not delete oldest");
  imm_out_a: assert property (ce && smp_valid &&
    smp_src == srm_pkg::SRC_IMM |=> imm_vld && imm_value ==
    $past(smp_value))
    else $error("immediate sample not delivered");
  auto_ac_a: assert property (ce && set_req && s_q.auto_dly[set_chan] &&
    set_func == srm_pkg::FN_AC && set_filter == srm_pkg::FLT_SLOW
    |=> settle_vld && settle_ms == srm_pkg::AC_SLOW_MS)
    else $error("ac slow settle wrong");
  mon_gate_a: assert property (ce && s_q.mon_en && mon_mux && !meter_ok
    |=> !mon_req)
    else $error("mux monitor without meter");
  mon_bare_a: assert property (ce && rd && addr == srm_pkg::A_MON_VAL
    |=> rdata == srm_sx($past(s_q.mon_val)))
    else $error("monitor query not bare value");

  wrap_c: cover property (ce && store_we && s_q.count == FULL);
  remove_c: cover property (ce && pop_w ##1 ce && pop_w);
  mon_owed_c: cover property (ce && sweep_end && !s_q.mon_taken &&
    scan_active);
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  logic sys_clk, rst, ce, wr, rd, rd_q, scan_start, scan_active, sweep_end;
  logic engine_idle, meter_ok, mon_mux, set_req, req, settle_vld, mon_req;
  logic tot_hold, imm_vld, mem_ovf_led, smp_valid;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, req_word, smp_time, w, mw;
  logic [1:0] set_func, set_filter, req_src, smp_src, smp_alarm;
  logic [3:0] set_chan, req_chan, smp_units, smp_chan, mon_chan;
  logic [15:0] settle_ms;
  logic [23:0] smp_value, imm_value;
  logic [31:0] q_rd[$], r_val[$], r_time[$], r_tag[$];
  logic [15:0] q_set[$];
  logic [23:0] q_imm[$];
  logic signed [31:0] v, s_min[16], s_max[16], s_last[16];
  longint s_sum[16];
  integer s_cnt[16];
  integer fails, samples_checked, seed, i, k;
  srm_store #(.DEPTH(8)) i_srm_store (.sys_clk(sys_clk), .rst(rst),
    .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .scan_start(scan_start), .scan_active(scan_active),
    .sweep_end(sweep_end), .engine_idle(engine_idle), .meter_ok(meter_ok),
    .mon_mux(mon_mux), .smp_valid(smp_valid), .smp_src(smp_src),
    .smp_value(smp_value), .smp_units(smp_units), .smp_time(smp_time),
    .smp_chan(smp_chan), .smp_alarm(smp_alarm), .set_req(set_req),
    .set_chan(set_chan), .set_func(set_func), .set_filter(set_filter),
    .settle_ms(settle_ms), .settle_vld(settle_vld), .mon_req(mon_req),
    .mon_chan(mon_chan), .tot_hold(tot_hold), .imm_value(imm_value),
    .imm_vld(imm_vld), .mem_ovf_led(mem_ovf_led));
  srm_eng_model i_srm_eng_model (.sys_clk(sys_clk), .rst(rst), .req(req),
    .req_src(req_src), .req_chan(req_chan), .req_word(req_word),
    .mon_req(mon_req), .smp_valid(smp_valid), .smp_src(smp_src),
    .smp_value(smp_value), .smp_units(smp_units), .smp_time(smp_time),
    .smp_chan(smp_chan), .smp_alarm(smp_alarm));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task report_and_stop;
    fails += q_rd.size() + q_set.size() + q_imm.size();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // watcher: results against the oldest note, plus a mirror of the store
  always @(posedge sys_clk) begin
    rd_q <= rd;
    if (rd_q && q_rd.size() > 0) chk("rdata", q_rd.pop_front(), rdata);
    if (settle_vld && q_set.size() > 0) begin
      chk("settle_ms", {16'h0, q_set.pop_front()}, {16'h0, settle_ms});
    end
    if (imm_vld && q_imm.size() > 0) begin
      chk("imm_value", {8'h0, q_imm.pop_front()}, {8'h0, imm_value});
    end
    if (ce && smp_valid && smp_src == srm_pkg::SRC_SCAN && scan_active) begin
      if (r_val.size() == 8) begin
        void'(r_val.pop_front());
        void'(r_time.pop_front());
        void'(r_tag.pop_front());
      end
      v = {{8{smp_value[23]}}, smp_value};
      r_val.push_back(v);
      r_time.push_back(smp_time);
      r_tag.push_back({20'h0, smp_chan, 2'h0, smp_alarm, smp_units});
      if (s_cnt[smp_chan] == 0 || v < s_min[smp_chan]) s_min[smp_chan] = v;
      if (s_cnt[smp_chan] == 0 || v > s_max[smp_chan]) s_max[smp_chan] = v;
      s_last[smp_chan] = v;
      s_sum[smp_chan] += v;
      s_cnt[smp_chan]++;
    end
  end
  task clear_model;
    r_val.delete();
    r_time.delete();
    r_tag.delete();
    for (k = 0; k < 16; k++) begin
      s_cnt[k] = 0;
      s_sum[k] = 0;
    end
  endtask
  task cyc(input logic r, input logic wt, input logic q, input logic s);
    rd <= r;
    wr <= wt;
    req <= q;
    set_req <= s;
    @(posedge sys_clk);
  endtask
  task idle(input integer n);
    repeat (n) cyc(1'b0, 1'b0, 1'b0, 1'b0);
  endtask
  task wreg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    cyc(1'b0, 1'b1, 1'b0, 1'b0);
  endtask
  task rreg(input logic [7:0] a, input logic [31:0] e);
    addr <= a;
    q_rd.push_back(e);
    cyc(1'b1, 1'b0, 1'b0, 1'b0);
  endtask
  task smp(input logic [1:0] s, input logic [3:0] c, input logic [31:0] d);
    req_src <= s;
    req_chan <= c;
    req_word <= d;
    cyc(1'b0, 1'b0, 1'b1, 1'b0);
  endtask
  task rec(input integer j);
    wreg(srm_pkg::A_REC_IDX, j);
    rreg(srm_pkg::A_REC_VAL, j < r_val.size() ? r_val[j] : 32'h0);
    rreg(srm_pkg::A_REC_TIME, j < r_val.size() ? r_time[j] : 32'h0);
    rreg(srm_pkg::A_REC_TAG, j < r_val.size() ? r_tag[j] : 32'h0);
  endtask
  task stats(input logic [3:0] c);
    wreg(srm_pkg::A_STAT_CHAN, {28'h0, c});
    rreg(srm_pkg::A_MIN, s_min[c]);
    rreg(srm_pkg::A_MAX, s_max[c]);
    rreg(srm_pkg::A_AVG, 32'(s_sum[c] / s_cnt[c]));
    rreg(srm_pkg::A_SCNT, s_cnt[c]);
    rreg(srm_pkg::A_PTP, s_max[c] - s_min[c]);
    rreg(srm_pkg::A_LAST, s_last[c]);
  endtask
  task rnd(input integer a);
    w = $random(seed);
    w[31:28] = a % 3;
  endtask
  task pulse_start;
    scan_start <= 1'b1;
    idle(1);
    scan_start <= 1'b0;
    clear_model();
  endtask
  initial begin
    #200000;
    fails++;
    report_and_stop();
  end
  initial begin
    {rst, ce, meter_ok, mon_mux} = 4'hF;
    {rd, wr, req, set_req, scan_start, scan_active, sweep_end} = 7'h0;
    {engine_idle, rd_q, addr, wdata, req_word, req_src, req_chan} = '0;
    {set_func, set_filter, set_chan} = '0;
    fails = 0;
    samples_checked = 0;
    seed = 84049;
    clear_model();
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rreg(srm_pkg::A_COUNT, 32'h0);
    rreg(srm_pkg::A_STATUS, 32'h0);
    smp(srm_pkg::SRC_SCAN, 4'h1, 32'h0000_0123);
    idle(3);
    rreg(srm_pkg::A_COUNT, 32'h0);
    scan_active <= 1'b1;
    pulse_start();
    for (i = 0; i < 6; i++) begin
      rnd(i);
      smp(srm_pkg::SRC_SCAN, (i % 2) ? 4'h2 : 4'h3, w);
    end
    idle(3);
    rreg(srm_pkg::A_COUNT, 32'h6);
    for (i = 0; i < 6; i++) rec(i);
    rreg(srm_pkg::A_COUNT, 32'h6);
    stats(4'h2);
    stats(4'h3);
    wreg(srm_pkg::A_STAT_CLR, 32'h2);
    s_cnt[2] = 0;
    s_sum[2] = 0;
    wreg(srm_pkg::A_STAT_CHAN, 32'h2);
    rreg(srm_pkg::A_SCNT, 32'h0);
    rreg(srm_pkg::A_AVG, 32'h0);
    stats(4'h3);
    wreg(srm_pkg::A_SCAN_LIST, 32'h20);
    wreg(srm_pkg::A_MON_CHAN, 32'h5);
    wreg(srm_pkg::A_CTRL, 32'h1);
    engine_idle <= 1'b1;
    idle(2);
    rreg(srm_pkg::A_STATUS, 32'h6);
    #1;
    chk("mon_req", 32'h1, {31'h0, mon_req});
    chk("mon_chan", 32'h5, {28'h0, mon_chan});
    chk("tot_hold", 32'h1, {31'h0, tot_hold});
    rnd(1);
    mw = {{8{w[23]}}, w[23:0]};
    smp(srm_pkg::SRC_MON, 4'h5, w);
    idle(1);
    rreg(srm_pkg::A_MON_VAL, mw);
    rreg(srm_pkg::A_ALQ, {1'b1, 25'h0, 4'h5,
      w[23] ? srm_pkg::ALM_LO : srm_pkg::ALM_HI});
    q_imm.push_back(w[23:0] ^ 24'h5A5A5A);
    smp(srm_pkg::SRC_IMM, 4'h5, w ^ 32'h005A5A5A);
    rnd(2);
    smp(srm_pkg::SRC_SCAN, 4'h2, w);
    idle(3);
    rreg(srm_pkg::A_MON_VAL, mw);
    rreg(srm_pkg::A_COUNT, 32'h7);
    engine_idle <= 1'b0;
    for (i = 0; i < 2; i++) begin
      sweep_end <= 1'b1;
      idle(1);
      sweep_end <= 1'b0;
      idle(2);
    end
    #1;
    chk("mon_owed", 32'h1, {31'h0, mon_req});
    smp(srm_pkg::SRC_MON, 4'h5, 32'h0000_0042);
    idle(3);
    #1;
    chk("mon_paid", 32'h0, {31'h0, mon_req});
    wreg(srm_pkg::A_SCAN_LIST, 32'h0);
    engine_idle <= 1'b1;
    idle(2);
    #1;
    chk("mon_block", 32'h0, {31'h0, mon_req});
    chk("tot_free", 32'h0, {31'h0, tot_hold});
    rreg(srm_pkg::A_STATUS, 32'h2);
    wreg(srm_pkg::A_SCAN_LIST, 32'h20);
    meter_ok <= 1'b0;
    idle(2);
    rreg(srm_pkg::A_STATUS, 32'h2);
    for (i = 0; i < 10; i++) begin
      rnd(i);
      smp(srm_pkg::SRC_SCAN, 4'h4, w);
    end
    idle(3);
    rreg(srm_pkg::A_COUNT, 32'h8);
    rreg(srm_pkg::A_STATUS, 32'h3);
    #1;
    chk("ovf_led", 32'h1, {31'h0, mem_ovf_led});
    rec(0);
    rec(7);
    rec(8);
    wreg(srm_pkg::A_REMOVE, 32'h2);
    for (i = 0; i < 2; i++) begin
      rreg(srm_pkg::A_REC_VAL, r_val.pop_front());
      rreg(srm_pkg::A_REC_TIME, r_time.pop_front());
      rreg(srm_pkg::A_REC_TAG, r_tag.pop_front());
    end
    rreg(srm_pkg::A_COUNT, 32'h6);
    rec(0);
    pulse_start();
    idle(1);
    rreg(srm_pkg::A_COUNT, 32'h0);
    rreg(srm_pkg::A_STATUS, 32'h2);
    wreg(srm_pkg::A_STAT_CHAN, 32'h3);
    rreg(srm_pkg::A_SCNT, 32'h0);
    #1;
    chk("ovf_clear", 32'h0, {31'h0, mem_ovf_led});
    smp(srm_pkg::SRC_SCAN, 4'h1, 32'h1000_0777);
    smp(srm_pkg::SRC_SCAN, 4'h1, 32'h2000_0888);
    idle(3);
    ce <= 1'b0;
    smp(srm_pkg::SRC_SCAN, 4'h1, 32'h0000_0999);
    idle(2);
    ce <= 1'b1;
    rreg(srm_pkg::A_COUNT, 32'h2);
    wreg(srm_pkg::A_CTRL, 32'h2);
    clear_model();
    idle(2);
    rreg(srm_pkg::A_COUNT, 32'h0);
    set_chan <= 4'h1;
    for (i = 0; i < 8; i++) begin
      set_func <= i < 3 ? srm_pkg::FN_AC : i < 6 ? srm_pkg::FN_FREQ :
        i == 6 ? srm_pkg::FN_DIG : srm_pkg::FN_OTHER;
      set_filter <= 2'(i % 3);
      q_set.push_back(i == 0 ? 16'h1B58 : i == 1 ? 16'h03E8 :
        i == 2 ? 16'h0078 : i == 3 ? 16'h0258 : i == 4 ? 16'h012C :
        i == 5 ? 16'h0064 : i == 6 ? 16'h0000 : 16'h0001);
      cyc(1'b0, 1'b0, 1'b0, 1'b1);
    end
    wreg(srm_pkg::A_DELAY, 32'h0001_0BB8);
    set_func <= srm_pkg::FN_AC;
    set_filter <= srm_pkg::FLT_SLOW;
    q_set.push_back(16'h0BB8);
    cyc(1'b0, 1'b0, 1'b0, 1'b1);
    wreg(srm_pkg::A_DELAY, 32'h8001_0000);
    q_set.push_back(16'h1B58);
    cyc(1'b0, 1'b0, 1'b0, 1'b1);
    idle(4);
    report_and_stop();
  end
endmodule
